// ===== rtl/drive_status_output_selector.sv
// Purpose: maps drive status conditions onto four multi-function output terminals
// Assumes: status inputs come from the control core, synchronous to aclk
// Notes: registers over AXI4-Lite, one 32-bit word each, bits above fields read zero
// Notes on behaviour
// - selection 6 closes during baseblock
// - selection 8 closed when keypad gives frequency
// - selection 9 closes on frequency reference loss
// - selection 10 closed when keypad gives run
// - selection 11 closes while a fault is active
// - selection 12 follows host written bit only
// - selection 14 closes during fault reset attempt
// - selection 16 closes above level plus width
// - selection 17 closes above level, hysteresis width
// - frequency comparators use frequency magnitude
// - selections 18/20 report level detection one/two
// - selection 22 closed during reverse rotation
// - selection 24 closes while regenerating
// - selection 25 closed while auto restart tries
// - selection 26 closes above 90% overload level
// - selection 27 closes above overheat level
// - selection 35 closed while outputting frequency
// - selection 36 mirrors drive enable input
// - four terminals, each with own selection
`timescale 1ns/1ps
module drive_status_output_selector
  import drive_out_pkg::*;
#(
  parameter int unsigned outputs = drive_out_pkg::num_outputs
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [drive_out_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [drive_out_pkg::data_w-1:0] s_axi_wdata,
  input wire logic [drive_out_pkg::strb_w-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [drive_out_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [drive_out_pkg::data_w-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status from the control core
  input wire logic in_baseblock,
  input wire logic freq_ref_from_keypad,
  input wire logic freq_ref_lost,
  input wire logic run_from_keypad,
  input wire logic fault_active,
  input wire logic fault_reset_attempt,
  input wire logic motor_reverse,
  input wire logic regenerating,
  input wire logic restart_trying,
  input wire logic freq_outputting,
  input wire logic drive_enable_input,
  input wire logic level_detect_two,
  // measured values from the control core
  input wire logic signed [drive_out_pkg::freq_w-1:0] output_frequency,
  input wire logic [drive_out_pkg::lvl_w-1:0] current_torque,
  input wire logic [drive_out_pkg::lvl_w-1:0] overload_accum,
  input wire logic [drive_out_pkg::lvl_w-1:0] overload_level,
  input wire logic [drive_out_pkg::lvl_w-1:0] heatsink_temp,
  // output terminals, 1 = closed
  output logic [outputs-1:0] relay_closed
);
  import drive_out_pkg::*;

  typedef struct packed {
    // selections and comparator settings
    logic [outputs-1:0][sel_w-1:0] sel;
    logic [freq_w-1:0] freq_detect_level;
    logic [freq_w-1:0] freq_detect_width;
    logic [outputs-1:0] host_bits;
    logic [lvl_w-1:0] level_detect_threshold_one;
    logic [lvl_w-1:0] level_detect_time_one;
    logic [lvl_w-1:0] overheat_level;

    // level detection one
    logic [lvl_w-1:0] level_cnt;
    logic level_det;

    // write halves held until both are in
    logic have_aw;
    logic [addr_w-1:0] aw_addr;
    logic have_w;
    logic [data_w-1:0] w_data;
    logic [strb_w-1:0] w_strb;

    // handshake and answer flops
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [data_w-1:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  // slot outputs and shared status
  logic [outputs-1:0] slot_closed;
  logic [freq_w-1:0] freq_mag;
  logic [snap_w-1:0] flags;

  // pre-alarm results and ratio products
  logic overload_pre;
  logic overheat_pre;
  logic [lvl_w+3:0] ol_lhs;
  logic [lvl_w+3:0] ol_rhs;

  drive_status_if st ();

  // byte-lane merge of a write into an old word
  function automatic logic [data_w-1:0] merge(input logic [data_w-1:0] old_v,
                                              input logic [data_w-1:0] new_v,
                                              input logic [strb_w-1:0] strb);
    logic [data_w-1:0] r;

    r = old_v;
    for (int i = 0; i < strb_w; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge

  // true when an address names a terminal selection register
  function automatic logic is_select(input logic [addr_w-1:0] a);
    return (a <= select_last) && (a[1:0] == 2'b00)
      && (a[addr_w-1:2] < outputs[addr_w-3:0]);
  endfunction : is_select

  // magnitude of output frequency, saturated at the most negative value
  always_comb
  begin
    // most negative value has no positive twin
    if (output_frequency[freq_w-1])
      freq_mag = (output_frequency == {1'b1, {(freq_w-1){1'b0}}})
        ? {1'b0, {(freq_w-1){1'b1}}} : freq_w'(-output_frequency);
    else
      freq_mag = output_frequency;
  end

  // pre-alarm comparators
  always_comb
  begin
    // ratio compared by products, no divider
    ol_lhs = {4'h0, overload_accum} * {{lvl_w{1'b0}}, ol_pre_den};
    ol_rhs = {4'h0, overload_level} * {{lvl_w{1'b0}}, ol_pre_num};
    overload_pre = ol_lhs > ol_rhs;
    overheat_pre = heatsink_temp > s_q.overheat_level;
  end

  // gathered status flags for every slot
  always_comb
  begin
    flags = '0;
    flags[snap_baseblock] = in_baseblock;
    flags[snap_freq_ref_local] = freq_ref_from_keypad;
    flags[snap_freq_ref_loss] = freq_ref_lost;
    flags[snap_run_local] = run_from_keypad;
    flags[snap_fault] = fault_active;
    flags[snap_fault_reset] = fault_reset_attempt;
    flags[snap_level_one] = s_q.level_det;
    flags[snap_level_two] = level_detect_two;
    flags[snap_reverse] = motor_reverse;
    flags[snap_regen] = regenerating;
    flags[snap_restart] = restart_trying;
    flags[snap_overload_pre] = overload_pre;
    flags[snap_overheat_pre] = overheat_pre;
    flags[snap_freq_output] = freq_outputting;
    flags[snap_drive_enable] = drive_enable_input;
  end

  assign st.flags = flags;
  assign st.freq_mag = freq_mag;
  assign st.freq_level = s_q.freq_detect_level;
  assign st.freq_width = s_q.freq_detect_width;

  // one slot per terminal, each with its own selection
  for (genvar g = 0; g < outputs; g++)
  begin : g_slot
    output_function_slot u_slot (
      .aclk(aclk),
      .aresetn(aresetn),
      .st(st),
      .select(s_q.sel[g]),
      .host_bit(s_q.host_bits[g]),
      .closed(slot_closed[g])
    );
  end

  // level detection one, counter, bus slave
  always_comb
  begin
    s_d = s_q;

    // level detect one: above threshold for one cycle more than the configured number of cycles
    if (current_torque > s_q.level_detect_threshold_one)
    begin
      if (s_q.level_cnt < s_q.level_detect_time_one)
        s_d.level_cnt = s_q.level_cnt + 16'h0001;
      s_d.level_det = (s_q.level_cnt >= s_q.level_detect_time_one);
    end
    else
    begin
      s_d.level_cnt = '0;
      s_d.level_det = 1'b0;
    end

    // capture write address and data in either order
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.have_aw = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.have_w = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // response retires
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // both halves present: perform the write
    if (s_q.have_aw && s_q.have_w && !s_q.bvalid)
    begin
      s_d.have_aw = 1'b0;
      s_d.have_w = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = resp_okay;
      // selection registers by word index
      if (is_select(s_q.aw_addr))
        s_d.sel[s_q.aw_addr[addr_w-1:2]] = sel_w'(merge(
          {{(data_w-sel_w){1'b0}}, s_q.sel[s_q.aw_addr[addr_w-1:2]]},
          s_q.w_data, s_q.w_strb));
      else
        case (s_q.aw_addr)
          off_freq_level: s_d.freq_detect_level = freq_w'(merge(
            {16'h0000, s_q.freq_detect_level}, s_q.w_data, s_q.w_strb));
          off_freq_width: s_d.freq_detect_width = freq_w'(merge(
            {16'h0000, s_q.freq_detect_width}, s_q.w_data, s_q.w_strb));
          off_host_bits: s_d.host_bits = outputs'(merge(
            {{(data_w-outputs){1'b0}}, s_q.host_bits}, s_q.w_data, s_q.w_strb));
          off_level_thresh: s_d.level_detect_threshold_one = lvl_w'(merge(
            {16'h0000, s_q.level_detect_threshold_one}, s_q.w_data, s_q.w_strb));
          off_level_time: s_d.level_detect_time_one = lvl_w'(merge(
            {16'h0000, s_q.level_detect_time_one}, s_q.w_data, s_q.w_strb));
          off_overheat_level: s_d.overheat_level = lvl_w'(merge(
            {16'h0000, s_q.overheat_level}, s_q.w_data, s_q.w_strb));
          // status words cannot be written
          off_terminal_state: s_d.bresp = resp_okay; // read only, write ignored
          off_status_snapshot: s_d.bresp = resp_okay; // read only, write ignored
          default: s_d.bresp = resp_slverr;
        endcase
    end

    // ready only while the matching holding slot is free
    s_d.awready = !s_d.have_aw;
    s_d.wready = !s_d.have_w;

    // read channel
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = resp_okay;
      s_d.rdata = '0;
      // unused upper bits read as zero
      if (is_select(s_axi_araddr))
        s_d.rdata[sel_w-1:0] = s_q.sel[s_axi_araddr[addr_w-1:2]];
      else
        case (s_axi_araddr)
          off_freq_level: s_d.rdata[freq_w-1:0] = s_q.freq_detect_level;
          off_freq_width: s_d.rdata[freq_w-1:0] = s_q.freq_detect_width;
          off_host_bits: s_d.rdata[outputs-1:0] = s_q.host_bits;
          off_terminal_state: s_d.rdata[outputs-1:0] = slot_closed;
          off_status_snapshot: s_d.rdata[snap_w-1:0] = flags;
          off_level_thresh: s_d.rdata[lvl_w-1:0] = s_q.level_detect_threshold_one;
          off_level_time: s_d.rdata[lvl_w-1:0] = s_q.level_detect_time_one;
          off_overheat_level: s_d.rdata[lvl_w-1:0] = s_q.overheat_level;
          default: s_d.rresp = resp_slverr;
        endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  // state register with reset values
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      // configuration to its reset values
      for (int i = 0; i < outputs; i++)
        s_q.sel[i] <= rst_select;
      s_q.freq_detect_level <= rst_freq_level;
      s_q.freq_detect_width <= rst_freq_width;
      s_q.host_bits <= rst_host_bits[outputs-1:0];
      s_q.level_detect_threshold_one <= rst_level_thresh;
      s_q.level_detect_time_one <= rst_level_time;
      s_q.overheat_level <= rst_overheat_level;
      // ready out of reset, nothing pending
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // terminals from each slot's own flop
  assign relay_closed = slot_closed;
endmodule : drive_status_output_selector

// ===== rtl/drive_out_pkg.sv
// Purpose: shared constants for the drive status output selector
// Assumes: 32-bit AXI4-Lite register bus, byte addresses, one word per register
// Notes: selection codes are the terminal function numbers, held in hex
package drive_out_pkg;
  // structure
  localparam int unsigned num_outputs = 4;
  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 32;
  localparam int unsigned strb_w = 4;
  localparam int unsigned sel_w = 8;
  localparam int unsigned freq_w = 16;
  localparam int unsigned lvl_w = 16;

  // register byte offsets
  localparam logic [7:0] off_select_base = 8'h00;
  localparam logic [7:0] off_freq_level = 8'h10;
  localparam logic [7:0] off_freq_width = 8'h14;
  localparam logic [7:0] off_host_bits = 8'h18;
  localparam logic [7:0] off_terminal_state = 8'h1c;
  localparam logic [7:0] off_status_snapshot = 8'h20;
  localparam logic [7:0] off_level_thresh = 8'h24;
  localparam logic [7:0] off_level_time = 8'h28;
  localparam logic [7:0] off_overheat_level = 8'h2c;
  localparam logic [7:0] select_last = 8'h0c;

  // reset values
  localparam logic [7:0] rst_select = 8'h00;
  localparam logic [15:0] rst_freq_level = 16'h0000;
  localparam logic [15:0] rst_freq_width = 16'h0000;
  localparam logic [3:0] rst_host_bits = 4'h0;
  localparam logic [15:0] rst_level_thresh = 16'hffff;
  localparam logic [15:0] rst_level_time = 16'h0000;
  localparam logic [15:0] rst_overheat_level = 16'hffff;

  // terminal function selections
  localparam logic [7:0] sel_baseblock = 8'h06;
  localparam logic [7:0] sel_freq_ref_local = 8'h08;
  localparam logic [7:0] sel_freq_ref_loss = 8'h09;
  localparam logic [7:0] sel_run_local = 8'h0a;
  localparam logic [7:0] sel_fault = 8'h0b;
  localparam logic [7:0] sel_host = 8'h0c;
  localparam logic [7:0] sel_fault_reset = 8'h0e;
  localparam logic [7:0] sel_freq_det_one = 8'h10;
  localparam logic [7:0] sel_freq_det_two = 8'h11;
  localparam logic [7:0] sel_level_one = 8'h12;
  localparam logic [7:0] sel_level_two = 8'h14;
  localparam logic [7:0] sel_reverse = 8'h16;
  localparam logic [7:0] sel_regen = 8'h18;
  localparam logic [7:0] sel_restart = 8'h19;
  localparam logic [7:0] sel_overload_pre = 8'h1a;
  localparam logic [7:0] sel_overheat_pre = 8'h1b;
  localparam logic [7:0] sel_freq_output = 8'h23;
  localparam logic [7:0] sel_drive_enable = 8'h24;
  localparam logic [7:0] sel_direct_last = 8'h31;
  localparam logic [7:0] sel_inv_first = 8'h64;
  localparam logic [7:0] sel_inv_last = 8'h95;

  // overload pre-alarm ratio, 9 / 10 of the detection level
  localparam logic [3:0] ol_pre_num = 4'h9;
  localparam logic [3:0] ol_pre_den = 4'ha;

  // axi responses
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // status snapshot bit positions
  localparam int unsigned snap_baseblock = 0;
  localparam int unsigned snap_freq_ref_local = 1;
  localparam int unsigned snap_freq_ref_loss = 2;
  localparam int unsigned snap_run_local = 3;
  localparam int unsigned snap_fault = 4;
  localparam int unsigned snap_fault_reset = 5;
  localparam int unsigned snap_level_one = 6;
  localparam int unsigned snap_level_two = 7;
  localparam int unsigned snap_reverse = 8;
  localparam int unsigned snap_regen = 9;
  localparam int unsigned snap_restart = 10;
  localparam int unsigned snap_overload_pre = 11;
  localparam int unsigned snap_overheat_pre = 12;
  localparam int unsigned snap_freq_output = 13;
  localparam int unsigned snap_drive_enable = 14;
  localparam int unsigned snap_w = 15;
endpackage : drive_out_pkg

// ===== rtl/drive_status_if.sv
// Purpose: status conditions shared by every output slot
// Assumes: all signals in the aclk domain
// Notes: src side is the top, dst side is each slot
`timescale 1ns/1ps
interface drive_status_if;
  import drive_out_pkg::*;
  logic [snap_w-1:0] flags;
  logic [freq_w-1:0] freq_mag;
  logic [freq_w-1:0] freq_level;
  logic [freq_w-1:0] freq_width;
  modport src (output flags, output freq_mag, output freq_level, output freq_width);
  modport dst (input flags, input freq_mag, input freq_level, input freq_width);
endinterface : drive_status_if

// ===== rtl/output_function_slot.sv
// Purpose: one output terminal, picks its condition from the selection code
// Assumes: status flags are synchronous to aclk
// Notes: hysteresis state of both frequency comparators lives here
`timescale 1ns/1ps
module output_function_slot
  import drive_out_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // shared status
  drive_status_if.dst st,
  // per terminal control
  input wire logic [drive_out_pkg::sel_w-1:0] select,
  input wire logic host_bit,
  // terminal, 1 = closed
  output logic closed
);
  import drive_out_pkg::*;

  typedef struct packed {
    logic det_one;
    logic det_two;
    logic out;
  } slot_state_t;

  slot_state_t s_q;
  slot_state_t s_d;
  logic [freq_w:0] upper_one;
  logic [freq_w-1:0] lower_two;
  logic [sel_w-1:0] base;
  logic cond;
  logic invert;

  // hysteresis comparators on magnitude, then selection and inversion
  always_comb
  begin
    s_d = s_q;
    upper_one = {1'b0, st.freq_level} + {1'b0, st.freq_width};
    lower_two = (st.freq_width > st.freq_level) ? '0 : st.freq_level - st.freq_width;
    if (!s_q.det_one && ({1'b0, st.freq_mag} > upper_one))
      s_d.det_one = 1'b1;
    else if (s_q.det_one && (st.freq_mag <= st.freq_level))
      s_d.det_one = 1'b0;
    if (!s_q.det_two && (st.freq_mag > st.freq_level))
      s_d.det_two = 1'b1;
    else if (s_q.det_two && (st.freq_mag <= lower_two))
      s_d.det_two = 1'b0;
    invert = (select >= sel_inv_first) && (select <= sel_inv_last);
    base = invert ? select - sel_inv_first : select;
    case (base)
      sel_baseblock: cond = st.flags[snap_baseblock];
      sel_freq_ref_local: cond = st.flags[snap_freq_ref_local];
      sel_freq_ref_loss: cond = st.flags[snap_freq_ref_loss];
      sel_run_local: cond = st.flags[snap_run_local];
      sel_fault: cond = st.flags[snap_fault];
      sel_host: cond = host_bit;
      sel_fault_reset: cond = st.flags[snap_fault_reset];
      sel_freq_det_one: cond = s_q.det_one;
      sel_freq_det_two: cond = s_q.det_two;
      sel_level_one: cond = st.flags[snap_level_one];
      sel_level_two: cond = st.flags[snap_level_two];
      sel_reverse: cond = st.flags[snap_reverse];
      sel_regen: cond = st.flags[snap_regen];
      sel_restart: cond = st.flags[snap_restart];
      sel_overload_pre: cond = st.flags[snap_overload_pre];
      sel_overheat_pre: cond = st.flags[snap_overheat_pre];
      sel_freq_output: cond = st.flags[snap_freq_output];
      sel_drive_enable: cond = st.flags[snap_drive_enable];
      default: cond = 1'b0;
    endcase
    if (!invert && (select > sel_direct_last))
      s_d.out = 1'b0;
    else
      s_d.out = cond ^ invert;
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign closed = s_q.out;
endmodule : output_function_slot

// ===== tb/drive_out_properties.sv
// Purpose: bus handshake and reset properties of the output selector
// Assumes: one aclk domain, sync active-low aresetn
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module drive_out_properties
  import drive_out_pkg::*;
#(
  parameter int unsigned outputs = 4
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [drive_out_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [drive_out_pkg::data_w-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // terminals
  input wire logic [outputs-1:0] relay_closed
);
  import drive_out_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // answers stand until taken
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  // answer latency
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // no new read while its answer is pending, no new write half in the cycle after one is taken
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  aw_block_a:
    assert property ((s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      and (s_axi_wvalid && s_axi_wready |=> !s_axi_wready))
    else $error("write accepted while busy");
  // terminals open and bus idle out of reset
  reset_quiet_a:
    assert property ($rose(aresetn) |-> relay_closed == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  unmapped_read_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h30
      |=> s_axi_rresp == resp_slverr && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  // main scenarios
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == resp_slverr);
  cover property ($rose(relay_closed[3]));
endmodule : drive_out_properties

bind drive_status_output_selector drive_out_properties #(.outputs(outputs)) i_props (.*);

// ===== tb/relay_reader.sv
// Purpose: external equipment reading the output contacts
// Assumes: contacts sampled on aclk
// Notes: one cycle of input-card delay
`timescale 1ns/1ps
module relay_reader
(
  // clock
  input wire logic aclk,
  // contacts from the drive, 1 = closed
  input wire logic [3:0] relay_closed,
  // last sampled contact state
  output logic [3:0] seen
);
  // every contact sampled each cycle
  always_ff @(posedge aclk)
    seen <= relay_closed;
endmodule : relay_reader

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the output selector
// Assumes: 200 MHz aclk, reset held 12 cycles
// Notes: terminals observed through the reader model
`timescale 1ns/1ps
module tb_top;
  import drive_out_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [11:0] st = '0;
  logic in_baseblock, freq_ref_from_keypad, freq_ref_lost, run_from_keypad, fault_active;
  logic fault_reset_attempt, motor_reverse, regenerating, restart_trying, freq_outputting;
  logic drive_enable_input, level_detect_two;
  logic [15:0] output_frequency = '0, current_torque = '0, overload_accum = '0;
  logic [15:0] overload_level = '0, heatsink_temp = '0;
  logic [3:0] relay_closed, seen;
  int failures = 0, checks = 0;
  logic [7:0] codes [12] = '{sel_baseblock, sel_freq_ref_local, sel_freq_ref_loss,
    sel_run_local, sel_fault, sel_fault_reset, sel_reverse, sel_regen, sel_restart,
    sel_freq_output, sel_drive_enable, sel_level_two};
  logic [15:0] fv [8] = '{16'h006e, 16'h0079, 16'h0065, 16'h0064, 16'h0051, 16'h0050,
    16'hff87, 16'hff9c};
  logic [1:0] ev [8] = '{2'b10, 2'b11, 2'b11, 2'b10, 2'b10, 2'b00, 2'b11, 2'b10};

  // status flags in the order of the codes table
  assign {level_detect_two, drive_enable_input, freq_outputting, restart_trying, regenerating,
    motor_reverse, fault_reset_attempt, fault_active, run_from_keypad, freq_ref_lost,
    freq_ref_from_keypad, in_baseblock} = st;

  drive_status_output_selector i_dut (.*);
  relay_reader i_reader (.*);

  // 5 ns clock
  always #2.5 aclk = ~aclk;

  task automatic give_verdict;
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // a used-up wait counts as a mismatch and ends the run
  task automatic bound(input int n);
    if (n >= 60)
    begin
      failures++;
      give_verdict;
    end
  endtask : bound

  // write, ready raised late so the answer is seen standing
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 60 && !(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1); n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (n == 2)
        s_axi_bready <= 1'b1;
    end
    bound(n);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 60 && !(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1); n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (n == 2)
        s_axi_rready <= 1'b1;
    end
    bound(n);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  // let the change reach the reader, then compare one terminal
  task automatic tchk(input int t, input logic e);
    repeat (4) @(posedge aclk);
    chk("terminal", {31'h0, seen[t]}, {31'h0, e});
  endtask : tchk

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(8'h24);
    chk("level threshold", rd, 32'h0000ffff);
    rd_reg(8'h2c);
    chk("overheat level", rd, 32'h0000ffff);
    rd_reg(8'h40);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, resp_slverr});
    wr(8'h40, 32'h1);
    chk("unmapped write", {30'h0, rsp}, {30'h0, resp_slverr});
    // one flag at a time, spread over all four terminals, then inverted
    for (int i = 0; i < 12; i++)
    begin
      wr(8'((i % 4) * 4), {24'h0, codes[i]});
      st <= 12'(1) << i;
      tchk(i % 4, 1'b1);
      st <= '0;
      tchk(i % 4, 1'b0);
      wr(8'((i % 4) * 4), {24'h0, codes[i] + 8'h64});
      tchk(i % 4, 1'b1);
    end
    // host-written contact
    wr(8'h00, {24'h0, sel_host});
    tchk(0, 1'b0);
    wr(8'h18, 32'h1);
    tchk(0, 1'b1);
    // reserved stays open, its inverse closes
    st <= '1;
    wr(8'h00, 32'h7);
    tchk(0, 1'b0);
    wr(8'h00, 32'h6b);
    tchk(0, 1'b1);
    st <= '0;
    // both hysteresis comparators, both directions
    wr(8'h10, 32'h64);
    wr(8'h14, 32'h14);
    wr(8'h04, {24'h0, sel_freq_det_one});
    wr(8'h08, {24'h0, sel_freq_det_two});
    for (int i = 0; i < 8; i++)
    begin
      output_frequency <= fv[i];
      repeat (4) @(posedge aclk);
      chk("freq detect", {30'h0, seen[2:1]}, {30'h0, ev[i]});
    end
    // level detection needs the time to pass
    wr(8'h24, 32'h32);
    wr(8'h28, 32'h3);
    wr(8'h0c, {24'h0, sel_level_one});
    current_torque <= 16'h33;
    repeat (6) @(posedge aclk);
    chk("level early", {31'h0, seen[3]}, 32'h0);
    tchk(3, 1'b1);
    current_torque <= 16'h32;
    tchk(3, 1'b0);
    // pre-alarms at their boundaries
    overload_level <= 16'h64;
    overload_accum <= 16'h5a;
    heatsink_temp <= 16'hc8;
    wr(8'h2c, 32'hc8);
    wr(8'h0c, {24'h0, sel_overload_pre});
    wr(8'h08, {24'h0, sel_overheat_pre});
    tchk(3, 1'b0);
    tchk(2, 1'b0);
    overload_accum <= 16'h5b;
    heatsink_temp <= 16'hc9;
    tchk(3, 1'b1);
    tchk(2, 1'b1);
    rd_reg(8'h1c);
    chk("terminal state", rd, 32'hd);
    rd_reg(8'h20);
    chk("status snapshot", rd, 32'h1800);
    give_verdict;
  end
endmodule : tb_top
